// File: hw/sbc_pkg.sv
// Constants and types shared by the mode controller and its serial port
package sbc_pkg;

  // Operating modes; Off comes first so a cleared state means Off
  typedef enum logic [2:0] {
    SBC_M_OFF,
    SBC_M_STANDBY,
    SBC_M_NORMAL,
    SBC_M_SLEEP,
    SBC_M_OVERTEMP
  } sbc_mode_t;

  // Transceiver states
  typedef enum logic [1:0] {
    SBC_XC_OFF,
    SBC_XC_LOWPWR,
    SBC_XC_ACTIVE
  } sbc_xcvr_t;

  // Watchdog states
  typedef enum logic [1:0] {
    SBC_WD_OFF,
    SBC_WD_TIMEOUT,
    SBC_WD_WINDOW
  } sbc_wdg_t;

  // Serial frame layout
  localparam int          FRAME_BITS  = 16;
  localparam logic [4:0]  FRAME_LEN   = 5'h10;
  localparam int          ADDR_MSB    = 15;
  localparam int          ADDR_LSB    = 13;
  localparam int          RO_BIT      = 12;
  localparam int          HDR_BITS    = 4;
  localparam logic [2:0]  ADDR_WD     = 3'h0;
  localparam logic [2:0]  ADDR_MODE   = 3'h1;

  // Payload field positions
  localparam int          WPB_BIT     = 11;
  localparam int          MSEL_MSB    = 11;
  localparam int          MSEL_LSB    = 10;
  localparam int          LPSEL_BIT   = 9;
  localparam int          LHC_BIT     = 8;

  // Mode field codes
  localparam logic [1:0]  MSEL_STBY   = 2'h0;
  localparam logic [1:0]  MSEL_SLEEP  = 2'h1;

  // Reset values
  localparam logic [1:0]  MSEL_RST    = 2'h0;
  localparam logic        LPSEL_RST   = 1'b0;
  localparam logic        WPB_RST     = 1'b0;
  localparam logic        LHC_RST     = 1'b0;

  // Reset pulse timing at the 10 MHz system clock
  localparam int CLK_HZ          = 10_000_000;
  localparam int T_RST_SHORT_US  = 3600;
  localparam int T_RST_LONG_US   = 20000;
  localparam int RST_SHORT_CYC   = T_RST_SHORT_US * (CLK_HZ / 1_000_000);
  localparam int RST_LONG_CYC    = T_RST_LONG_US * (CLK_HZ / 1_000_000);
  localparam int RCNT_W          = 20;

endpackage

// File: hw/sbc_mode_ctrl.sv
// Operating-mode controller with serial port front end
`timescale 1ns/1ps

module sbc_mode_ctrl
  import sbc_pkg::*;
#(
  parameter int SHORT_RST_CYC = RST_SHORT_CYC,
  parameter int LONG_RST_CYC  = RST_LONG_CYC
) (
  // System clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Analog comparator and pin inputs, asynchronous
  input  wire logic       bat_below_poff,
  input  wire logic       bat_above_pon,
  input  wire logic       temp_above_act,
  input  wire logic       temp_below_rel,
  input  wire logic       wake_pending,
  input  wire logic       interrupt_line_n,
  input  wire logic       watchdog_disable_pin,
  // Configuration from logic on ref_clk
  input  wire logic [1:0] wake_src_en,
  input  wire logic       rst_len_long_sel,
  // Open-drain reset line
  input  wire logic       reset_line_n_i,
  output logic            reset_line_n_o,
  output logic            reset_line_n_oe,
  // Serial port, clocked by the master
  input  wire logic       serial_clk,
  input  wire logic       serial_select_pin,
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  output logic            serial_out_oe,
  // Power, transceiver and watchdog control
  output logic            main_regulator_en,
  output logic [1:0]      xcvr_mode,
  output logic            bus_high_z,
  output logic [1:0]      wdg_mode,
  output logic            fallback_n,
  output logic [2:0]      op_mode
);

  // Parameter sanity
  if (SHORT_RST_CYC < 1 || SHORT_RST_CYC >= (1 << RCNT_W) ||
      LONG_RST_CYC < 1 || LONG_RST_CYC >= (1 << RCNT_W)) begin : g_chk
    $error("sbc_mode_ctrl: reset pulse length out of range");
  end

  // Synchroniser bit positions
  localparam int IN_POFF  = 0;
  localparam int IN_PON   = 1;
  localparam int IN_OTACT = 2;
  localparam int IN_OTREL = 3;
  localparam int IN_WAKE  = 4;
  localparam int IN_INTL  = 5;
  localparam int IN_WATCHDOG_DISABLE_PIN = 6;
  localparam int IN_RSTIN = 7;
  localparam int IN_CS    = 8;
  localparam int NSYNC    = 9;

  // System clock domain state
  typedef struct packed {
    logic [NSYNC-1:0]  sy1;
    logic [NSYNC-1:0]  sy2;
    logic              cs_d3;
    sbc_mode_t         mode;
    logic [1:0]        msel;
    logic              lpsel;
    logic              wpb;
    logic              fallback_control_bit;
    logic [RCNT_W-1:0] rcnt;
    logic [2:0]        drv_hist;
    logic [11:0]       rb_wd;
    logic [11:0]       rb_mode;
    logic              sleep_rej;
    logic              reg_en;
    sbc_xcvr_t         xcvr;
    sbc_wdg_t          wdg;
    logic              rst_drv;
    logic              frm_ack;
  } sbc_ref_st_t;

  // Serial clock domain state, falling edge
  typedef struct packed {
    logic       fresh;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [2:0] addr;
    logic       frm_tag;
  } sbc_spi_st_t;

  sbc_ref_st_t       q;
  sbc_ref_st_t       d;
  sbc_spi_st_t       sq;
  sbc_spi_st_t       sd;
  logic              sdo_q;
  logic              sdo_d;
  logic              cs_rise;
  logic              accept;
  logic              wr_mode;
  logic              ext_rst;
  logic              sleep_ok;
  logic [1:0]        req;
  logic [RCNT_W-1:0] rlen;

  // Reset pulse length for the selected width
  function automatic logic [RCNT_W-1:0] pulse_len(input logic long_sel);
    pulse_len = long_sel ? RCNT_W'(LONG_RST_CYC) : RCNT_W'(SHORT_RST_CYC);
  endfunction

  // Frame capture: bits sampled on falling serial clock edge
  always_comb begin
    sd = sq;
    if (sq.fresh) begin
      sd.fresh = 1'b0;
      sd.cnt   = 5'h01;
      sd.sh    = {15'h0000, serial_in_pin};
      // New frame tag; ack is quiet while a frame runs
      sd.frm_tag = ~q.frm_ack;
    end else begin
      sd.sh = {sq.sh[14:0], serial_in_pin};
      if (sq.cnt != 5'h1F) begin
        sd.cnt = sq.cnt + 5'h01;
      end
      if (sq.cnt == 5'h02) begin
        sd.addr = {sq.sh[1:0], serial_in_pin};
      end
    end
  end

  // Select high re-arms the frame without a clock edge
  always_ff @(negedge serial_clk or posedge serial_select_pin) begin
    if (serial_select_pin) begin
      sq.fresh <= 1'b1;
    end else begin
      sq <= sd;
    end
  end

  // Reply bit: header reads zero, then the addressed payload
  always_comb begin
    logic [4:0]  k;
    logic [11:0] pay;
    k   = sq.fresh ? 5'h00 : sq.cnt;
    pay = 12'h000;
    if (sq.addr == ADDR_WD) begin
      pay = q.rb_wd;
    end else if (sq.addr == ADDR_MODE) begin
      pay = q.rb_mode;
    end
    sdo_d = 1'b0;
    if (k >= 5'(HDR_BITS) && k < 5'(FRAME_BITS)) begin
      sdo_d = pay[4'(5'(FRAME_BITS - 1) - k)];
    end
  end

  // Output data changes on the rising serial clock edge
  always_ff @(posedge serial_clk or posedge serial_select_pin) begin
    if (serial_select_pin) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  // Serial output drive
  assign serial_out_pin = sdo_q;
  assign serial_out_oe  = ~serial_select_pin;

  // Mode controller next state
  always_comb begin
    d       = q;
    d.sy1   = {serial_select_pin, reset_line_n_i, watchdog_disable_pin,
               interrupt_line_n, wake_pending, temp_below_rel,
               temp_above_act, bat_above_pon, bat_below_poff};
    d.sy2   = q.sy1;
    d.cs_d3 = q.sy2[IN_CS];
    d.drv_hist  = {q.drv_hist[1:0], q.rst_drv};
    d.sleep_rej = 1'b0;
    // Frame is stable once select is high and the clock idles
    cs_rise  = q.sy2[IN_CS] & ~q.cs_d3;
    // A frame with no clock edge leaves the tag unchanged
    accept   = cs_rise && sq.frm_tag != q.frm_ack
               && sq.cnt == FRAME_LEN
               && !sq.sh[RO_BIT];
    if (cs_rise && sq.frm_tag != q.frm_ack) begin
      d.frm_ack = ~q.frm_ack;
    end
    wr_mode  = accept && sq.sh[ADDR_MSB:ADDR_LSB] == ADDR_MODE;
    req      = sq.sh[MSEL_MSB:MSEL_LSB];
    ext_rst  = ~q.sy2[IN_RSTIN] && q.drv_hist == 3'h0;
    sleep_ok = q.sy2[IN_INTL] && !q.sy2[IN_WAKE]
               && |wake_src_en;
    rlen     = pulse_len(rst_len_long_sel);
    if (q.rcnt != '0) begin
      d.rcnt = q.rcnt - RCNT_W'(1);
    end
    // Plain register writes
    if (accept && sq.sh[ADDR_MSB:ADDR_LSB] == ADDR_WD) begin
      d.wpb = sq.sh[WPB_BIT];
    end
    if (wr_mode) begin
      d.lpsel = sq.sh[LPSEL_BIT];
      if (!sq.sh[LHC_BIT]) begin
        d.fallback_control_bit = 1'b0;
      end
    end
    // Mode transitions, power-off first, overtemp next in Standby and Normal
    case (q.mode)
      SBC_M_OFF: begin
        if (q.sy2[IN_PON] && !q.sy2[IN_POFF]) begin
          d.mode = SBC_M_STANDBY;
          d.rcnt = rlen;
          d.msel = MSEL_STBY;
        end
      end
      SBC_M_STANDBY, SBC_M_NORMAL: begin
        if (q.sy2[IN_POFF]) begin
          d.mode = SBC_M_OFF;
        end else if (q.sy2[IN_OTACT]) begin
          d.mode = SBC_M_OVERTEMP;
          d.fallback_control_bit  = 1'b1;
        end else if (q.mode == SBC_M_NORMAL && ext_rst) begin
          d.mode = SBC_M_STANDBY;
          d.msel = MSEL_STBY;
        end else if (wr_mode) begin
          d.msel = req;
          if (req == MSEL_SLEEP) begin
            if (sleep_ok) begin
              d.mode = SBC_M_SLEEP;
            end else begin
              d.mode      = SBC_M_STANDBY;
              d.msel      = MSEL_STBY;
              d.rcnt      = RCNT_W'(SHORT_RST_CYC);
              d.sleep_rej = 1'b1;
            end
          end else if (req[1]) begin
            d.mode = SBC_M_NORMAL;
          end else begin
            d.mode = SBC_M_STANDBY;
          end
        end
      end
      SBC_M_SLEEP: begin
        if (q.sy2[IN_POFF]) begin
          d.mode = SBC_M_OFF;
        end else if (q.sy2[IN_WAKE]) begin
          d.mode = SBC_M_STANDBY;
          d.rcnt = rlen;
          d.msel = MSEL_STBY;
        end
      end
      SBC_M_OVERTEMP: begin
        if (q.sy2[IN_POFF]) begin
          d.mode = SBC_M_OFF;
        end else if (q.sy2[IN_OTREL]) begin
          d.mode = SBC_M_STANDBY;
          d.rcnt = rlen;
          d.msel = MSEL_STBY;
        end
      end
      default: begin
        d.mode = SBC_M_OFF;
      end
    endcase
    // Controls follow the next mode so they align with it
    d.reg_en = d.mode == SBC_M_STANDBY
               || d.mode == SBC_M_NORMAL;
    case (d.mode)
      SBC_M_NORMAL: begin
        d.xcvr = d.lpsel ? SBC_XC_LOWPWR : SBC_XC_ACTIVE;
        d.wdg  = q.sy2[IN_WATCHDOG_DISABLE_PIN] ? SBC_WD_OFF :
                 (d.wpb ? SBC_WD_TIMEOUT : SBC_WD_WINDOW);
      end
      SBC_M_STANDBY: begin
        d.xcvr = d.lpsel ? SBC_XC_LOWPWR : SBC_XC_OFF;
        d.wdg  = (q.sy2[IN_WATCHDOG_DISABLE_PIN] || d.wpb) ?
                 SBC_WD_OFF : SBC_WD_TIMEOUT;
      end
      SBC_M_SLEEP: begin
        d.xcvr = d.lpsel ? SBC_XC_LOWPWR : SBC_XC_OFF;
        d.wdg  = SBC_WD_OFF;
      end
      default: begin
        d.xcvr = SBC_XC_OFF;
        d.wdg  = SBC_WD_OFF;
      end
    endcase
    d.rst_drv = d.rcnt != '0 || d.mode == SBC_M_SLEEP
                || d.mode == SBC_M_OVERTEMP
                || d.mode == SBC_M_OFF;
    // Readback frozen while a frame may be in flight
    if (q.sy2[IN_CS]) begin
      d.rb_wd   = {d.wpb, 3'h0, q.sy2[IN_WATCHDOG_DISABLE_PIN], ~d.reg_en,
                   1'b1, 5'h00};
      d.rb_mode = {d.msel, d.lpsel, d.fallback_control_bit, 5'h00, d.mode};
    end
  end

  // System clock register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q       <= '0;
      q.mode  <= SBC_M_OFF;
      q.msel  <= MSEL_RST;
      q.lpsel <= LPSEL_RST;
      q.wpb   <= WPB_RST;
      q.fallback_control_bit   <= LHC_RST;
      q.sy1   <= {NSYNC{1'b1}};
      q.sy2   <= {NSYNC{1'b1}};
      q.cs_d3 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs from flip-flops
  assign main_regulator_en = q.reg_en;
  assign xcvr_mode         = q.xcvr;
  assign bus_high_z        = q.mode == SBC_M_OFF
                             || q.mode == SBC_M_OVERTEMP;
  assign wdg_mode          = q.wdg;
  assign fallback_n        = ~q.fallback_control_bit;
  assign reset_line_n_o    = 1'b0;
  assign reset_line_n_oe   = q.rst_drv;
  assign op_mode           = q.mode;

  // Checks on the system clock domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_POFF: assert property (
    q.sy2[IN_POFF] |=> q.mode == SBC_M_OFF && !main_regulator_en
                       && bus_high_z)
    else $error("power-off did not reach Off");

  AST_PON: assert property (
    q.mode == SBC_M_OFF && q.sy2[IN_PON] && !q.sy2[IN_POFF]
    |=> q.mode == SBC_M_STANDBY && q.rcnt != '0 && reset_line_n_oe)
    else $error("power-on did not give Standby with reset");

  AST_OT: assert property (
    (q.mode == SBC_M_NORMAL || q.mode == SBC_M_STANDBY)
    && q.sy2[IN_OTACT] && !q.sy2[IN_POFF]
    |=> q.mode == SBC_M_OVERTEMP && !fallback_n && reset_line_n_oe
        && !main_regulator_en && bus_high_z)
    else $error("overtemperature entry wrong");

  AST_SLEEP_OUT: assert property (
    q.mode == SBC_M_SLEEP |-> !main_regulator_en
    && wdg_mode == SBC_WD_OFF && reset_line_n_oe)
    else $error("sleep outputs wrong");

  AST_WAKE: assert property (
    q.mode == SBC_M_SLEEP && q.sy2[IN_WAKE] && !q.sy2[IN_POFF]
    |=> q.mode == SBC_M_STANDBY && q.msel == MSEL_STBY
        && main_regulator_en ##1 reset_line_n_oe)
    else $error("wake from sleep wrong");

  AST_REJ: assert property (
    q.sleep_rej |-> q.mode == SBC_M_STANDBY
    && q.rcnt == RCNT_W'(SHORT_RST_CYC) && reset_line_n_oe)
    else $error("refused sleep lacks short reset");

  AST_NORMAL: assert property (
    q.mode == SBC_M_STANDBY && wr_mode && req[1]
    && !q.sy2[IN_POFF] && !q.sy2[IN_OTACT]
    |=> q.mode == SBC_M_NORMAL && main_regulator_en)
    else $error("mode write did not give Normal");

  AST_BADLEN: assert property (
    cs_rise && sq.cnt != FRAME_LEN |=> $stable(q.wpb) && $stable(q.lpsel))
    else $error("short or long frame changed a register");

  AST_SDO_Z: assert property (
    serial_select_pin |-> !serial_out_oe)
    else $error("serial output driven while deselected");

  AST_STBY_WDG: assert property (
    q.mode == SBC_M_STANDBY && $stable(q.mode) && q.wpb
    |-> wdg_mode == SBC_WD_OFF)
    else $error("standby watchdog not off with policy set");

  COV_SLEEP: cover property (
    q.mode == SBC_M_STANDBY ##1 q.mode == SBC_M_SLEEP);
  COV_NORMAL: cover property (
    q.mode == SBC_M_STANDBY ##1 q.mode == SBC_M_NORMAL);
  COV_OT: cover property (
    q.mode == SBC_M_OVERTEMP ##1 q.mode == SBC_M_STANDBY);
  COV_REJ: cover property (q.sleep_rej);

endmodule

// File: verif/sbc_host_model.sv
// Serial master model standing in for the host microcontroller
`timescale 1ns/1ps

module sbc_host_model (
  // Serial pins towards the device
  output logic      serial_clk,
  output logic      serial_select_pin,
  output logic      serial_in_pin,
  // Reply from the device
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe
);
  localparam int HALF_NS = 3;

  // Start: clock parked low, device selected for the first 1 ns
  initial begin
    serial_clk        = 1'b0;
    serial_select_pin = 1'b0;
    serial_in_pin     = 1'b0;
    // A clean rising select arms the frame logic
    #1;
    serial_select_pin = 1'b1;
  end

  // One frame of nbits, MSB first; reply gathered before each fall
  task automatic xfer(input logic [15:0] word, input int nbits,
                      output logic [15:0] rx);
    rx = 16'h0000;
    // Gap after the previous frame before selecting again
    #600;
    serial_select_pin = 1'b0;
    #350;
    for (int k = 0; k < nbits; k++) begin
      serial_in_pin = word[15 - k];
      serial_clk    = 1'b1;
      #HALF_NS;
      rx[15 - k]    = serial_out_pin;
      serial_clk    = 1'b0;
      #HALF_NS;
    end
    #HALF_NS;
    serial_select_pin = 1'b1;
    // Released data line must not keep its last value
    serial_in_pin     = ~serial_in_pin;
  endtask
endmodule

// File: verif/sbc_mode_ctrl_tb.sv
// Self-checking bench for the operating-mode controller
`timescale 1ns/1ps

module sbc_mode_ctrl_tb
  import sbc_pkg::*;
;
  localparam int SHORT = 8;
  localparam int LONG  = 20;

  // One ordinary case: pins, optional frame, expected outputs
  typedef struct {
    logic [4:0]  pins;
    logic        spi;
    logic [15:0] word;
    sbc_mode_t   mode;
    logic        reg_en;
    logic [1:0]  xc;
    logic        hz;
  } sbc_row_t;

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        bat_below_poff = 1'b0;
  logic        bat_above_pon = 1'b0;
  logic        temp_above_act = 1'b0;
  logic        temp_below_rel = 1'b0;
  logic        wake_pending = 1'b0;
  logic        interrupt_line_n = 1'b1;
  logic        watchdog_disable_pin = 1'b0;
  logic [1:0]  wake_src_en = 2'b01;
  logic        rst_len_long_sel = 1'b0;
  logic        ext_pull = 1'b0;
  wire logic   reset_line_n_i;
  logic        reset_line_n_oe;
  wire logic   serial_clk;
  wire logic   serial_select_pin;
  wire logic   serial_in_pin;
  logic        serial_out_pin;
  logic        serial_out_oe;
  logic        main_regulator_en;
  logic [1:0]  xcvr_mode;
  logic        bus_high_z;
  logic [1:0]  wdg_mode;
  logic        fallback_n;
  logic [2:0]  op_mode;
  logic [15:0] rx;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;

  // Open-drain reset line with pull-up
  assign reset_line_n_i = ~(reset_line_n_oe | ext_pull);

  always #50 ref_clk = ~ref_clk;

  sbc_mode_ctrl #(.SHORT_RST_CYC(SHORT), .LONG_RST_CYC(LONG)) u_dut (
    .ref_clk(ref_clk), .rst(rst),
    .bat_below_poff(bat_below_poff), .bat_above_pon(bat_above_pon),
    .temp_above_act(temp_above_act), .temp_below_rel(temp_below_rel),
    .wake_pending(wake_pending), .interrupt_line_n(interrupt_line_n),
    .watchdog_disable_pin(watchdog_disable_pin),
    .wake_src_en(wake_src_en), .rst_len_long_sel(rst_len_long_sel),
    .reset_line_n_i(reset_line_n_i), .reset_line_n_o(),
    .reset_line_n_oe(reset_line_n_oe),
    .serial_clk(serial_clk), .serial_select_pin(serial_select_pin),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe),
    .main_regulator_en(main_regulator_en), .xcvr_mode(xcvr_mode),
    .bus_high_z(bus_high_z), .wdg_mode(wdg_mode),
    .fallback_n(fallback_n), .op_mode(op_mode)
  );

  sbc_host_model u_host (
    .serial_clk(serial_clk), .serial_select_pin(serial_select_pin),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe)
  );

  // Ordinary cases, pins are {poff, pon, overheat, release, wake}
  sbc_row_t rows [11] = '{
    '{5'b01000, 1'b0, 16'h0000, SBC_M_STANDBY,  1'b1, 2'h0, 1'b0},
    '{5'b01000, 1'b1, 16'h2800, SBC_M_NORMAL,   1'b1, 2'h2, 1'b0},
    '{5'b01000, 1'b1, 16'h2A00, SBC_M_NORMAL,   1'b1, 2'h1, 1'b0},
    '{5'b01000, 1'b1, 16'h2200, SBC_M_STANDBY,  1'b1, 2'h1, 1'b0},
    '{5'b01000, 1'b1, 16'h2600, SBC_M_SLEEP,    1'b0, 2'h1, 1'b0},
    '{5'b01001, 1'b0, 16'h0000, SBC_M_STANDBY,  1'b1, 2'h1, 1'b0},
    '{5'b01000, 1'b1, 16'h2C00, SBC_M_NORMAL,   1'b1, 2'h2, 1'b0},
    '{5'b01100, 1'b0, 16'h0000, SBC_M_OVERTEMP, 1'b0, 2'h0, 1'b1},
    '{5'b01010, 1'b0, 16'h0000, SBC_M_STANDBY,  1'b1, 2'h0, 1'b0},
    '{5'b11000, 1'b0, 16'h0000, SBC_M_OFF,      1'b0, 2'h0, 1'b1},
    '{5'b01000, 1'b0, 16'h0000, SBC_M_STANDBY,  1'b1, 2'h0, 1'b0}
  };

  // Verdict and end of run
  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare a design value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Compare a measured count against a window
  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string what);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("MISMATCH %0t %s count %0d", $time, what, got);
    end
  endtask

  // Frame through the host model, then back on the falling edge
  task automatic spi(input logic [15:0] w, input int nb);
    u_host.xfer(w, nb, rx);
    repeat (6) @(negedge ref_clk);
  endtask

  // Bounded wait for a mode
  task automatic wait_mode(input sbc_mode_t m);
    int n;
    n = 0;
    while (op_mode !== m && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // Length of the reset pulse after Standby entry
  task automatic pulse(input int len);
    int n;
    n = 0;
    wait_mode(SBC_M_STANDBY);
    while (reset_line_n_oe === 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk_rng(n, len - 1, len + 1, "reset pulse");
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      stop_test();
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      @(negedge ref_clk);
      {bat_below_poff, bat_above_pon, temp_above_act, temp_below_rel,
       wake_pending} = rows[i].pins;
      if (rows[i].spi) begin
        spi(rows[i].word, 16);
      end
      wait_mode(rows[i].mode);
      chk(op_mode, rows[i].mode, "mode");
      chk(main_regulator_en, rows[i].reg_en, "reg");
      chk(xcvr_mode, rows[i].xc, "xcvr");
      chk(bus_high_z, rows[i].hz, "bus");
    end
    chk(fallback_n, 1'b0, "fallback");
    chk(serial_out_oe, 1'b0, "out oe");
    // Read-back: header zero, mode and fallback bit visible
    spi(16'h3000, 16);
    chk(rx[15:12], 4'h0, "hdr");
    chk(rx[2:0], SBC_M_STANDBY, "rd mode");
    chk(rx[8], 1'b1, "rd fb");
    spi(16'h2000, 16);
    chk(fallback_n, 1'b1, "fb clear");
    // Watchdog in Standby: policy 0/1, disable pin
    for (int k = 0; k < 3; k++) begin
      watchdog_disable_pin = (k == 2);
      spi((k == 1) ? 16'h0800 : 16'h0000, 16);
      repeat (3) @(negedge ref_clk);
      chk(wdg_mode, (k == 0) ? SBC_WD_TIMEOUT : SBC_WD_OFF, "wdg");
    end
    // Read-only and short frames change nothing
    spi(16'h3800, 16);
    repeat (5) @(negedge ref_clk);
    chk(op_mode, SBC_M_STANDBY, "ro");
    spi(16'h2800, 15);
    repeat (5) @(negedge ref_clk);
    chk(op_mode, SBC_M_STANDBY, "short frame");
    // External reset in Normal
    spi(16'h2800, 16);
    wait_mode(SBC_M_NORMAL);
    ext_pull = 1'b1;
    repeat (6) @(negedge ref_clk);
    ext_pull = 1'b0;
    wait_mode(SBC_M_STANDBY);
    chk(op_mode, SBC_M_STANDBY, "ext rst");
    // Refused sleep: interrupt, wake pending, no source; always short
    rst_len_long_sel = 1'b1;
    for (int c = 0; c < 3; c++) begin
      repeat (30) @(negedge ref_clk);
      spi(16'h2800, 16);
      wait_mode(SBC_M_NORMAL);
      interrupt_line_n = (c != 0);
      wake_pending     = (c == 1);
      wake_src_en      = (c == 2) ? 2'b00 : 2'b01;
      u_host.xfer(16'h2400, 16, rx);
      pulse(SHORT);
      spi(16'h3000, 16);
      chk(rx[11:10], 2'b00, "mode field");
      interrupt_line_n = 1'b1;
      wake_pending     = 1'b0;
      wake_src_en      = 2'b01;
    end
    // Power cycle with long pulse
    bat_below_poff = 1'b1;
    wait_mode(SBC_M_OFF);
    chk(op_mode, SBC_M_OFF, "poff");
    bat_below_poff = 1'b0;
    pulse(LONG);
    // Reset in mid-run
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk(op_mode, SBC_M_OFF, "rst mode");
    chk(main_regulator_en, 1'b0, "rst reg");
    chk(bus_high_z, 1'b1, "rst bus");
    chk(fallback_n, 1'b1, "rst fb");
    rst = 1'b0;
    @(negedge ref_clk);
    chk(op_mode, SBC_M_OFF, "rel mode");
    chk(reset_line_n_oe, 1'b1, "rel rst line");
    pulse(LONG);
    stop_test();
  end
endmodule
